// ==== common/cps_defs.vh ====
// Constants shared by the node logic files.
// Included by bare name; definitions only.
`ifndef CPS_DEFS_VH
`define CPS_DEFS_VH

// Bit rate codes
`define CPS_RATE_20K 3'h0
`define CPS_RATE_50K 3'h1
`define CPS_RATE_125K 3'h2
`define CPS_RATE_250K 3'h3
`define CPS_RATE_500K 3'h4
`define CPS_RATE_1M 3'h5
`define CPS_RATE_DEFAULT `CPS_RATE_125K

// Master limits
`define CPS_M_MAX_PDO 9'h100
`define CPS_M_MAX_BYTES 11'h766
// Slave limits
`define CPS_S_MAX_PDO 9'h008
`define CPS_S_PDO_BYTES 4'h8
// Request and reply regions, bytes
`define CPS_AREA_BYTES 7'h40
// Auto download and emergency depth
`define CPS_ADL_MAX 5'h14
`define CPS_EMCY_DEPTH 5

// Mapped data type size codes
`define CPS_TYPE_8 2'h0
`define CPS_TYPE_16 2'h1
`define CPS_TYPE_32 2'h2
`define CPS_TYPE_64 2'h3

// Timing
`define CPS_CLK_HZ 10000000
`define CPS_HB_TIMEOUT_MS 100

`endif

// ==== design/cps_hb_mon.v ====
// Heartbeat loss monitor, one timer per remote node.
// Assumes hb_rx is a one-cycle pulse for the node heard.
`timescale 1ns/100ps
`default_nettype none
module cps_hb_mon #(
    parameter NODES = 64,
    parameter NW = 6,
    parameter TW = 24,
    parameter TIMEOUT = 1000000
) (
    input wire clk,
    input wire rst_n,
    input wire hb_rx,
    input wire [NW-1:0] hb_node,
    output reg [NODES-1:0] lost_r
);
    localparam [TW-1:0] LIMIT = TIMEOUT[TW-1:0];
    reg [TW-1:0] tmr_r [0:NODES-1];
    reg [NODES-1:0] seen_r;
    integer i;

    // Only nodes that have been heard once are watched; loss is
    // declared on heartbeat silence alone, never by guarding polls.
    always @(posedge clk)
    begin
        for (i = 0; i < NODES; i = i + 1)
        begin
            if (!rst_n)
            begin
                tmr_r[i] <= {TW{1'b0}};
                seen_r[i] <= 1'b0;
                lost_r[i] <= 1'b0;
            end
            else if (hb_rx && hb_node == i[NW-1:0])
            begin
                tmr_r[i] <= {TW{1'b0}};
                seen_r[i] <= 1'b1;
                lost_r[i] <= 1'b0;
            end
            else if (seen_r[i] && !lost_r[i])
            begin
                if (tmr_r[i] >= LIMIT)
                    lost_r[i] <= 1'b1;
                else
                    tmr_r[i] <= tmr_r[i] + {{(TW-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

// ==== design/cps_emcy_buf.v ====
// Emergency store: a small ring of codes per node.
// A read naming a node whose count is zero is ignored.
`timescale 1ns/100ps
`default_nettype none
`include "cps_defs.vh"
module cps_emcy_buf #(
    parameter NODES = 64,
    parameter NW = 6,
    parameter DEPTH = `CPS_EMCY_DEPTH
) (
    input wire clk,
    input wire rst_n,
    input wire em_wr,
    input wire [NW-1:0] em_wr_node,
    input wire [15:0] em_wr_code,
    input wire em_rd,
    input wire [NW-1:0] em_rd_node,
    output reg [15:0] em_rd_code_r,
    output reg em_rd_valid_r,
    output reg [2:0] em_rd_count_r
);
    reg [15:0] mem [0:NODES*DEPTH-1];
    reg [2:0] head_r [0:NODES-1];
    reg [2:0] cnt_r [0:NODES-1];
    integer i;
    localparam [2:0] DEPTH3 = DEPTH;

    function [2:0] wrap_inc;
        input [2:0] p;
        begin
            wrap_inc = (p == DEPTH - 1) ? 3'h0 : p + 3'h1;
        end
    endfunction

    function [2:0] slot;
        input [2:0] h;
        input [2:0] c;
        reg [3:0] s;
        begin
            s = {1'b0, h} + {1'b0, c};
            slot = (s >= DEPTH) ? s[2:0] - DEPTH3 : s[2:0];
        end
    endfunction

    wire rd_ok = em_rd && cnt_r[em_rd_node] != 3'h0;
    wire same = rd_ok && em_wr && em_rd_node == em_wr_node;
    wire [2:0] wcnt = cnt_r[em_wr_node];
    wire full = wcnt == DEPTH;

    // A full ring drops its oldest code for the new one.
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            for (i = 0; i < NODES; i = i + 1)
            begin
                head_r[i] <= 3'h0;
                cnt_r[i] <= 3'h0;
            end
            em_rd_code_r <= 16'h0000;
            em_rd_valid_r <= 1'b0;
            em_rd_count_r <= 3'h0;
        end
        else
        begin
            em_rd_valid_r <= rd_ok;
            em_rd_count_r <= cnt_r[em_rd_node];
            if (rd_ok)
            begin
                em_rd_code_r <= mem[em_rd_node*DEPTH + head_r[em_rd_node]];
                head_r[em_rd_node] <= wrap_inc(head_r[em_rd_node]);
                if (!same)
                    cnt_r[em_rd_node] <= cnt_r[em_rd_node] - 3'h1;
            end
            if (em_wr)
            begin
                mem[em_wr_node*DEPTH + slot(head_r[em_wr_node], wcnt)]
                    <= em_wr_code;
                if (full && !same)
                    head_r[em_wr_node] <= wrap_inc(head_r[em_wr_node]);
                else if (!same)
                    cnt_r[em_wr_node] <= wcnt + 3'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== design/cps_node.v ====
// CANopen node control: roles, NMT, SDO, emergencies, bit rate and
// the SYNC-driven PDO send scheduler.
// Assumes one clock; all pulse inputs are one cycle wide and
// synchronous. Frames are built by the CAN controller beyond.
//
// How it works
// (R1) Master issues NMT state commands to move slaves between states.
// (R2) Node loss found only by heartbeat timeout; no guarding polls.
// (R3) Master accepts up to 256 RxPDOs totalling at most 1894 bytes.
// (R4) Master accepts up to 256 TxPDOs totalling at most 1894 bytes.
// (R5) Each PDO runs synchronous to SYNC or asynchronous, by mode bit; here one sync_mode bit sets all PDOs.
// (R6) Master issues standard SDO read and write requests to slaves.
// (R7) Automatic parameter download sends at most 20 SDO writes.
// (R8) Up to 5 emergency codes per slave held for later reading.
// (R9) Bit rate is one of 20K, 50K, 125K, 250K, 500K or 1M.
// (R10) Mapped items take 8, 16, 32 or 64 bits by data type.
// (R11) Slave role allows 8 TxPDOs and 8 RxPDOs of 8 bytes each.
// (R12) Slave role sends an emergency on every local error or alarm.
// (R13) Request and reply regions are 64 bytes each; beyond is refused.
// (R14) SYNC start clears the timer; sending needs count over half period.
// (R15) At refresh with PDO eligible: send, then clear the timer.
// (R16) At refresh below half or already sent: no send, keep counting.
// (R17) Unsent period and new SYNC above half: send and clear timer.
// (R18) Asynchronous mode sends at refresh only when mapped data changed.
// (R19) Bit rate after reset is 125K until changed.
// (R20) Half period is period shifted right by one, compared strictly.
`timescale 1ns/100ps
`default_nettype none
`include "cps_defs.vh"
module cps_node #(
    parameter NODES = 64,
    parameter NW = 6,
    parameter PW = 24,
    parameter HB_TIMEOUT = `CPS_CLK_HZ / 1000 * `CPS_HB_TIMEOUT_MS
) (
    input wire clk,
    input wire rst_n,
    input wire role_master,
    input wire sync_mode,
    input wire [PW-1:0] sync_period,
    input wire sync_start,
    input wire scan_refresh,
    input wire data_changed,
    input wire map_clear,
    input wire map_add,
    input wire map_dir_tx,
    input wire map_new_pdo,
    input wire [1:0] map_type,
    input wire nmt_req,
    input wire [7:0] nmt_cmd,
    input wire [NW-1:0] nmt_node,
    input wire [6:0] req_ofs,
    input wire sdo_req,
    input wire sdo_write,
    input wire [NW-1:0] sdo_node,
    input wire [15:0] sdo_index,
    input wire [7:0] sdo_sub,
    input wire [31:0] sdo_data,
    input wire sdo_done,
    input wire adl_start,
    input wire [4:0] adl_entries,
    input wire hb_rx,
    input wire [NW-1:0] hb_node,
    input wire em_rx,
    input wire [NW-1:0] em_rx_node,
    input wire [15:0] em_rx_code,
    input wire em_rd,
    input wire [NW-1:0] em_rd_node,
    input wire local_fault,
    input wire [15:0] local_code,
    input wire rate_set,
    input wire [2:0] rate_sel,
    output reg pdo_send_r,
    output reg [PW-1:0] sync_cnt_r,
    output reg nmt_tx_r,
    output reg [7:0] nmt_tx_cmd_r,
    output reg [NW-1:0] nmt_tx_node_r,
    output reg sdo_tx_r,
    output reg sdo_tx_write_r,
    output reg [NW-1:0] sdo_tx_node_r,
    output reg [15:0] sdo_tx_index_r,
    output reg [7:0] sdo_tx_sub_r,
    output reg [31:0] sdo_tx_data_r,
    output reg adl_busy_r,
    output reg [4:0] adl_idx_r,
    output reg emcy_tx_r,
    output reg [15:0] emcy_tx_code_r,
    output reg [2:0] can_rate_r,
    output reg [8:0] rx_pdo_cnt_r,
    output reg [8:0] tx_pdo_cnt_r,
    output reg [10:0] rx_bytes_r,
    output reg [10:0] tx_bytes_r,
    output reg map_err_r,
    output reg req_err_r,
    output wire [NODES-1:0] node_lost_r,
    output wire [15:0] em_rd_code_r,
    output wire em_rd_valid_r,
    output wire [2:0] em_rd_count_r
);
    localparam HB_TW = 24;
    localparam ADL_IDLE = 1'b0;
    localparam ADL_WAIT = 1'b1;

    reg sent_r;
    reg adl_st_r;
    reg adl_st_nxt;
    reg [4:0] adl_last_r;
    reg [8:0] pdo_lim;
    reg [10:0] byte_lim;
    reg [10:0] add_bytes;
    reg [3:0] pdo_fill_r;

    // Byte size of one mapped item
    function [3:0] type_bytes;
        input [1:0] t;
        begin
            case (t)
                `CPS_TYPE_8: type_bytes = 4'h1;
                `CPS_TYPE_16: type_bytes = 4'h2;
                `CPS_TYPE_32: type_bytes = 4'h4;
                default: type_bytes = 4'h8;
            endcase
        end
    endfunction

    function rate_ok;
        input [2:0] r;
        begin
            rate_ok = r <= `CPS_RATE_1M;
        end
    endfunction

    // PDO scheduler
    wire [PW-1:0] half = sync_period >> 1; // R20
    wire above = sync_cnt_r > half; // R20
    wire eligible = above && !sent_r; // R14
    wire [PW-1:0] cnt_inc = sync_cnt_r + {{(PW-1){1'b0}}, 1'b1};

    // A late SYNC with nothing sent yet still catches the period; the
    // count restarts anyway as every SYNC opens a new period.
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            sync_cnt_r <= {PW{1'b0}};
            sent_r <= 1'b0;
            pdo_send_r <= 1'b0;
        end
        else if (!sync_mode)
        begin
            sync_cnt_r <= {PW{1'b0}};
            sent_r <= 1'b0;
            pdo_send_r <= scan_refresh && data_changed; // R5 R18
        end
        else if (sync_start)
        begin
            pdo_send_r <= eligible; // R17
            sync_cnt_r <= {PW{1'b0}}; // R14 R17
            sent_r <= 1'b0;
        end
        else if (scan_refresh && eligible)
        begin
            pdo_send_r <= 1'b1; // R15
            sync_cnt_r <= {PW{1'b0}}; // R15
            sent_r <= 1'b1;
        end
        else
        begin
            pdo_send_r <= 1'b0; // R16
            sync_cnt_r <= cnt_inc; // R14 R16
        end
    end

    // Mapping bookkeeping and limits per role
    always @*
    begin
        pdo_lim = role_master ? `CPS_M_MAX_PDO : `CPS_S_MAX_PDO; // R3 R4 R11
        byte_lim = role_master ? `CPS_M_MAX_BYTES
                               : {7'h00, `CPS_S_PDO_BYTES} << 3; // R11
        add_bytes = {7'h00, type_bytes(map_type)}; // R10
    end

    wire [8:0] cur_pdo = map_dir_tx ? tx_pdo_cnt_r : rx_pdo_cnt_r;
    wire [10:0] cur_bytes = map_dir_tx ? tx_bytes_r : rx_bytes_r;
    wire [8:0] new_pdo = cur_pdo + {8'h00, map_new_pdo};
    wire [10:0] new_bytes = cur_bytes + add_bytes;
    wire [3:0] fill_base = map_new_pdo ? 4'h0 : pdo_fill_r;
    wire [4:0] new_fill = {1'b0, fill_base} + {1'b0, add_bytes[3:0]};
    wire slave_over = !role_master
        && new_fill > {1'b0, `CPS_S_PDO_BYTES}; // R11
    wire map_bad = new_pdo > pdo_lim || new_bytes > byte_lim
        || slave_over || (new_pdo == 9'h000);

    // An item breaking a limit is refused; counts stay.
    always @(posedge clk)
    begin
        if (!rst_n || map_clear)
        begin
            rx_pdo_cnt_r <= 9'h000;
            tx_pdo_cnt_r <= 9'h000;
            rx_bytes_r <= 11'h000;
            tx_bytes_r <= 11'h000;
            pdo_fill_r <= 4'h0;
            map_err_r <= 1'b0;
        end
        else if (map_add)
        begin
            if (map_bad)
                map_err_r <= 1'b1; // R3 R4 R11
            else
            begin
                pdo_fill_r <= new_fill[3:0];
                if (map_dir_tx)
                begin
                    tx_pdo_cnt_r <= new_pdo; // R4
                    tx_bytes_r <= new_bytes; // R4 R10
                end
                else
                begin
                    rx_pdo_cnt_r <= new_pdo; // R3
                    rx_bytes_r <= new_bytes; // R3 R10
                end
            end
        end
    end

    // Requests need master role and an offset in its region
    wire ofs_ok = req_ofs < `CPS_AREA_BYTES; // R13
    wire any_req = nmt_req || sdo_req || adl_start;
    wire nmt_go = nmt_req && role_master && ofs_ok;
    wire sdo_go = sdo_req && role_master && ofs_ok && !adl_busy_r;

    always @(posedge clk)
    begin
        if (!rst_n)
            req_err_r <= 1'b0;
        else if (any_req && (!ofs_ok || !role_master))
            req_err_r <= 1'b1; // R13
        else if (any_req)
            req_err_r <= 1'b0;
    end

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            nmt_tx_r <= 1'b0;
            nmt_tx_cmd_r <= 8'h00;
            nmt_tx_node_r <= {NW{1'b0}};
        end
        else
        begin
            nmt_tx_r <= nmt_go; // R1
            if (nmt_go)
            begin
                nmt_tx_cmd_r <= nmt_cmd; // R1
                nmt_tx_node_r <= nmt_node;
            end
        end
    end

    // Auto download walks entries one SDO write at a time
    always @*
    begin
        adl_st_nxt = adl_st_r;
        case (adl_st_r)
            ADL_IDLE:
                if (adl_start && role_master && ofs_ok
                    && adl_entries != 5'h00)
                    adl_st_nxt = ADL_WAIT;
            ADL_WAIT:
                if (sdo_done && adl_idx_r == adl_last_r)
                    adl_st_nxt = ADL_IDLE;
            default:
                adl_st_nxt = ADL_IDLE;
        endcase
    end

    wire adl_launch = adl_st_r == ADL_IDLE && adl_st_nxt == ADL_WAIT;
    wire adl_step = adl_st_r == ADL_WAIT && sdo_done
        && adl_idx_r != adl_last_r;

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            adl_st_r <= ADL_IDLE;
            adl_busy_r <= 1'b0;
            adl_idx_r <= 5'h00;
            adl_last_r <= 5'h00;
        end
        else
        begin
            adl_st_r <= adl_st_nxt;
            adl_busy_r <= adl_st_nxt == ADL_WAIT;
            if (adl_launch)
            begin
                adl_idx_r <= 5'h00;
                adl_last_r <= (adl_entries > `CPS_ADL_MAX ? `CPS_ADL_MAX
                    : adl_entries) - 5'h01; // R7
            end
            else if (adl_step)
                adl_idx_r <= adl_idx_r + 5'h01; // R7
        end
    end

    // Download steps reuse the SDO input fields
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            sdo_tx_r <= 1'b0;
            sdo_tx_write_r <= 1'b0;
            sdo_tx_node_r <= {NW{1'b0}};
            sdo_tx_index_r <= 16'h0000;
            sdo_tx_sub_r <= 8'h00;
            sdo_tx_data_r <= 32'h00000000;
        end
        else
        begin
            sdo_tx_r <= sdo_go || adl_launch || adl_step; // R6 R7
            if (sdo_go || adl_launch || adl_step)
            begin
                sdo_tx_write_r <= sdo_write || !sdo_go; // R6 R7
                sdo_tx_node_r <= sdo_node;
                sdo_tx_index_r <= sdo_index;
                sdo_tx_sub_r <= sdo_sub;
                sdo_tx_data_r <= sdo_data;
            end
        end
    end

    // Slave side emergency report
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            emcy_tx_r <= 1'b0;
            emcy_tx_code_r <= 16'h0000;
        end
        else
        begin
            emcy_tx_r <= local_fault && !role_master; // R12
            if (local_fault && !role_master)
                emcy_tx_code_r <= local_code;
        end
    end

    always @(posedge clk)
    begin
        if (!rst_n)
            can_rate_r <= `CPS_RATE_DEFAULT; // R19
        else if (rate_set && rate_ok(rate_sel))
            can_rate_r <= rate_sel; // R9
    end

    cps_hb_mon #(
        .NODES(NODES),
        .NW(NW),
        .TW(HB_TW),
        .TIMEOUT(HB_TIMEOUT)
    ) u_hb (
        .clk(clk),
        .rst_n(rst_n),
        .hb_rx(hb_rx), // R2
        .hb_node(hb_node),
        .lost_r(node_lost_r)
    );

    cps_emcy_buf #(
        .NODES(NODES),
        .NW(NW)
    ) u_em (
        .clk(clk),
        .rst_n(rst_n),
        .em_wr(em_rx && role_master), // R8
        .em_wr_node(em_rx_node),
        .em_wr_code(em_rx_code),
        .em_rd(em_rd && role_master),
        .em_rd_node(em_rd_node),
        .em_rd_code_r(em_rd_code_r),
        .em_rd_valid_r(em_rd_valid_r),
        .em_rd_count_r(em_rd_count_r)
    );
endmodule
`default_nettype wire

// ==== sim/cps_node_chk.sv ====
// Port checks for cps_node.
// Bound into every cps_node; one clock, synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module cps_node_chk #(
    parameter PW = 24
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic role_master,
    input wire logic sync_mode,
    input wire logic [PW-1:0] sync_period,
    input wire logic sync_start,
    input wire logic scan_refresh,
    input wire logic data_changed,
    input wire logic nmt_req,
    input wire logic [7:0] nmt_cmd,
    input wire logic [6:0] req_ofs,
    input wire logic local_fault,
    input wire logic [15:0] local_code,
    input wire logic rate_set,
    input wire logic [2:0] rate_sel,
    input wire logic pdo_send_r,
    input wire logic [PW-1:0] sync_cnt_r,
    input wire logic nmt_tx_r,
    input wire logic [7:0] nmt_tx_cmd_r,
    input wire logic adl_busy_r,
    input wire logic [4:0] adl_idx_r,
    input wire logic emcy_tx_r,
    input wire logic [15:0] emcy_tx_code_r,
    input wire logic [2:0] can_rate_r
);
    logic any_r;
    logic ref_r;
    logic start_d_r;
    wire logic late = sync_cnt_r > (sync_period >> 1);

    // Refresh sends close a period; start sends leave it open
    always @(posedge clk)
    begin
        if (!rst_n || sync_start || !sync_mode)
        begin
            any_r <= 1'b0;
            ref_r <= 1'b0;
        end
        else if (pdo_send_r)
        begin
            any_r <= 1'b1;
            ref_r <= ref_r | !start_d_r;
        end
        start_d_r <= sync_start && rst_n;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_sync_clear: assert property (
        sync_mode && sync_start |=> sync_cnt_r == '0)
        else $error("timer not cleared");
    chk_timer_runs: assert property (
        sync_mode && !sync_start |=>
        pdo_send_r || sync_cnt_r == $past(sync_cnt_r) + 1'b1)
        else $error("timer stuck");
    chk_due_send: assert property (
        sync_mode && (sync_start || scan_refresh) && late && !any_r
        |=> pdo_send_r && sync_cnt_r == '0)
        else $error("send missing");
    chk_no_early: assert property (
        sync_mode && !sync_start && scan_refresh && !late |=> !pdo_send_r)
        else $error("early send");
    chk_no_resend: assert property (
        sync_mode && (sync_start || scan_refresh) && ref_r |=> !pdo_send_r)
        else $error("second send");
    chk_async_send: assert property (
        !sync_mode |=>
        pdo_send_r == ($past(scan_refresh) && $past(data_changed)))
        else $error("async send wrong");
    chk_nmt_issue: assert property (
        nmt_req && role_master && req_ofs < 7'h40 |=>
        nmt_tx_r && nmt_tx_cmd_r == $past(nmt_cmd))
        else $error("no state command");
    chk_emcy_local: assert property (
        local_fault && !role_master |=>
        emcy_tx_r && emcy_tx_code_r == $past(local_code))
        else $error("fault not reported");
    chk_rate_pick: assert property (
        rate_set && rate_sel <= 3'h5 |=> can_rate_r == $past(rate_sel))
        else $error("rate not taken");
    chk_rate_keep: assert property (
        rate_set && rate_sel > 3'h5 |=> $stable(can_rate_r))
        else $error("bad rate taken");
    chk_adl_bound: assert property (
        adl_busy_r |-> adl_idx_r < 5'h14)
        else $error("download overrun");

    cover property (sync_mode && scan_refresh ##1 pdo_send_r);
    cover property (sync_mode && sync_start ##1 pdo_send_r);
    cover property (adl_busy_r && adl_idx_r == 5'h13);
endmodule

bind cps_node cps_node_chk #(.PW(PW)) u_chk (.*);
`default_nettype wire

// ==== sim/cps_far_node.sv ====
// Remote node model beyond the CAN port.
// Answers SDOs after 1 or 6 cycles; beats heartbeats when enabled.
`timescale 1ns/100ps
`default_nettype none
module cps_far_node #(
    parameter int GAP = 8,
    parameter logic [5:0] NODE_ID = 6'h03
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sdo_tx_r,
    input wire logic slow,
    input wire logic hb_en,
    output logic sdo_done,
    output logic hb_rx,
    output logic [5:0] hb_node
);
    int wait_r;
    int beat_r;

    // Node field is junk between beats
    assign hb_node = hb_rx ? NODE_ID : ~NODE_ID;

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            wait_r <= 0;
            beat_r <= 0;
            sdo_done <= 1'b0;
            hb_rx <= 1'b0;
        end
        else
        begin
            sdo_done <= (wait_r == 1);
            if (sdo_tx_r)
                wait_r <= slow ? 6 : 1;
            else if (wait_r != 0)
                wait_r <= wait_r - 1;
            hb_rx <= hb_en && beat_r == 0;
            beat_r <= (beat_r == GAP - 1) ? 0 : beat_r + 1;
        end
    end
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for cps_node with a remote node model.
// Heartbeat timeout cut to 20 cycles.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk, rst_n, role_master, sync_mode, sync_start, scan_refresh;
    logic data_changed, map_clear, map_add, map_dir_tx, map_new_pdo;
    logic nmt_req, sdo_req, sdo_write, sdo_done, adl_start, hb_rx, em_rx;
    logic em_rd, local_fault, rate_set, slow, hb_en, pdo_send_r, nmt_tx_r;
    logic sdo_tx_r, sdo_tx_write_r, adl_busy_r, emcy_tx_r, map_err_r;
    logic req_err_r, em_rd_valid_r;
    logic [23:0] sync_period, sync_cnt_r;
    logic [1:0] map_type;
    logic [7:0] nmt_cmd, sdo_sub, nmt_tx_cmd_r, sdo_tx_sub_r;
    logic [5:0] nmt_node, sdo_node, hb_node, em_rx_node, em_rd_node;
    logic [5:0] nmt_tx_node_r, sdo_tx_node_r;
    logic [6:0] req_ofs;
    logic [15:0] sdo_index, em_rx_code, local_code, sdo_tx_index_r;
    logic [15:0] emcy_tx_code_r, em_rd_code_r;
    logic [31:0] sdo_data, sdo_tx_data_r;
    logic [4:0] adl_entries, adl_idx_r;
    logic [2:0] rate_sel, can_rate_r, em_rd_count_r;
    logic [8:0] rx_pdo_cnt_r, tx_pdo_cnt_r;
    logic [10:0] rx_bytes_r, tx_bytes_r;
    logic [63:0] node_lost_r;
    int fails = 0;
    int compares = 0;
    int n;

    cps_node #(.HB_TIMEOUT(20)) dut (.*);
    cps_far_node far (.*);

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        if (fails == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Start or refresh after g edges, then check the send flag
    task automatic sched(input logic st, input int g, input logic dc,
        input logic exp);
        tick(g);
        {sync_start, scan_refresh, data_changed} <= {st, !st, dc};
        @(posedge clk);
        {sync_start, scan_refresh} <= 2'h0;
        #1;
        check(pdo_send_r, exp);
    endtask

    task automatic t_sync;
        @(posedge clk);
        {sync_mode, sync_period} <= {1'b1, 24'h00000b};
        sched(1'b1, 1, 1'b0, 1'b0);
        sched(1'b0, 5, 1'b0, 1'b0);
        sched(1'b1, 1, 1'b0, 1'b1);
        check(sync_cnt_r, 24'h0);
        sched(1'b1, 1, 1'b0, 1'b0);
        sched(1'b0, 6, 1'b0, 1'b1);
        check(sync_cnt_r, 24'h0);
        sched(1'b0, 7, 1'b0, 1'b0);
        sched(1'b1, 1, 1'b0, 1'b0);
        tick(3);
        #1;
        check(sync_cnt_r, 24'h3);
    endtask

    task automatic t_rate;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            {rate_set, rate_sel} <= {1'b1, i[2:0]};
            @(posedge clk);
            rate_set <= 1'b0;
            #1;
            check(can_rate_r, i < 6 ? i : 5);
        end
    endtask

    task automatic t_nmt;
        @(posedge clk);
        {nmt_cmd, nmt_node, nmt_req} <= {8'h01, 6'h05, 1'b1};
        @(posedge clk);
        req_ofs <= 7'h40;
        #1;
        check({nmt_tx_r, nmt_tx_cmd_r, nmt_tx_node_r}, 15'h4045);
        @(posedge clk);
        {nmt_req, req_ofs} <= 8'h00;
        #1;
        check({nmt_tx_r, req_err_r}, 2'h1);
    endtask

    task automatic t_sdo;
        @(posedge clk);
        sdo_req <= 1'b1;
        @(posedge clk);
        sdo_req <= 1'b0;
        #1;
        check({sdo_tx_r, sdo_tx_write_r, sdo_tx_node_r}, 8'h84);
        check({sdo_tx_index_r, sdo_tx_sub_r, sdo_tx_data_r},
            56'h20000112345678);
        tick(4);
    endtask

    task automatic t_adl;
        @(posedge clk);
        {slow, sdo_write, adl_entries, adl_start} <= {2'h3, 5'h19, 1'b1};
        @(posedge clk);
        adl_start <= 1'b0;
        n = 0;
        for (int k = 0; k < 400; k++)
        begin
            #1;
            n += int'(sdo_tx_r === 1'b1);
            if (adl_busy_r !== 1'b1)
                break;
            @(posedge clk);
        end
        check(n, 20);
    endtask

    task automatic t_emcy;
        @(posedge clk);
        {role_master, local_code, local_fault} <= {1'b0, 16'h8130, 1'b1};
        @(posedge clk);
        {local_fault, role_master} <= 2'h1;
        {em_rx_node, em_rd_node} <= {2{6'h02}};
        #1;
        check({emcy_tx_r, emcy_tx_code_r}, 17'h18130);
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk);
            em_rx <= 1'b1;
            em_rx_code <= em_rx_code + 16'h0001;
        end
        @(posedge clk);
        em_rx <= 1'b0;
        @(posedge clk);
        em_rd <= 1'b1;
        @(posedge clk);
        em_rd <= 1'b0;
        #1;
        check({em_rd_valid_r, em_rd_count_r, em_rd_code_r}, 20'hd1001);
    endtask

    task automatic t_map;
        @(posedge clk);
        map_clear <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk);
            {map_clear, map_add} <= 2'h1;
            map_type <= i[1:0];
            map_new_pdo <= (i < 4);
        end
        @(posedge clk);
        map_add <= 1'b0;
        #1;
        check({rx_pdo_cnt_r, rx_bytes_r, map_err_r}, 21'h004020);
    endtask

    task automatic t_hb;
        tick(10);
        #1;
        check(node_lost_r, 64'h0);
        @(posedge clk);
        hb_en <= 1'b0;
        tick(30);
        #1;
        check(node_lost_r, 64'h8);
        @(posedge clk);
        hb_en <= 1'b1;
        tick(12);
        #1;
        check(node_lost_r, 64'h0);
    endtask

    initial
    begin
        {rst_n, sync_mode, sync_start, scan_refresh, data_changed} = '0;
        {map_clear, map_add, map_dir_tx, map_new_pdo, map_type} = '0;
        {nmt_req, sdo_req, adl_start, em_rx, em_rd, local_fault} = '0;
        {rate_set, slow, sync_period, nmt_cmd, nmt_node, req_ofs} = '0;
        {adl_entries, em_rx_node, em_rd_node, rate_sel, local_code} = '0;
        {role_master, hb_en} = 2'h3;
        em_rx_code = 16'h0fff;
        sdo_write = 1'b0;
        sdo_node = 6'h04;
        sdo_index = 16'h2000;
        sdo_sub = 8'h01;
        sdo_data = 32'h12345678;
        tick(2);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check({can_rate_r, pdo_send_r}, 4'h4);
        sched(1'b0, 2, 1'b1, 1'b1);
        sched(1'b0, 1, 1'b0, 1'b0);
        check(sync_cnt_r, 24'h0);
        t_sync;
        t_rate;
        t_nmt;
        t_sdo;
        t_adl;
        t_emcy;
        t_map;
        t_hb;
        final_report;
    end

    // Run needs under 1500 cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        fails++;
        final_report;
    end
endmodule
`default_nettype wire
